// ===== src/srs_regs.svh
// Constants of the two-wire register access slave
`ifndef SRS_REGS_SVH
`define SRS_REGS_SVH

// Upper six bits of the seven-bit slave address; bit 0 comes from the select pin
`define SRS_DEV_ADDR_HI   6'h26
// Highest register index and number of registers
`define SRS_REG_TOP       8'h19
`define SRS_REG_COUNT     26
// Reset value of every control register
`define SRS_REG_RESET     8'h00
// Bit count value of the acknowledge slot
`define SRS_ACK_SLOT      4'h8
// Bit count value of the last data bit
`define SRS_LAST_BIT      4'h7

`endif

// ===== src/srs_pkg.sv
// Types of the two-wire register access slave
package srs_pkg;

    typedef enum logic [5:0] {
        SRS_IDLE   = 6'b000001,
        SRS_ADDR   = 6'b000010,
        SRS_REG    = 6'b000100,
        SRS_WDATA  = 6'b001000,
        SRS_RDATA  = 6'b010000,
        SRS_IGNORE = 6'b100000
    } srs_state_t;

endpackage

// ===== src/srs_slave.sv
// Two-wire serial slave giving a bus master access to the control registers
`timescale 1ns/1ps
`include "srs_regs.svh"

module srs_slave (
    input  wire logic                               i_clock,
    input  wire logic                               i_rstn,
    input  wire logic                               i_scl,
    input  wire logic                               i_sda,
    output logic                                    o_sda_out,
    output logic                                    o_sda_oe,
    input  wire logic                               i_slave_address_select_pin,
    output logic                                    o_reg_write,
    output logic [7:0]                              o_reg_addr,
    output logic [7:0]                              o_reg_data,
    output logic [`SRS_REG_COUNT*8-1:0]             o_reg_file
);

    // ------------------------------------------------------------
    // Start and stop detection on data line edges
    // ------------------------------------------------------------
    logic                   start_tgl;
    logic                   stop_tgl;
    logic                   start_seen;
    logic                   stop_seen;
    logic                   start_pend;
    logic                   stop_pend;

    always_ff @(negedge i_sda or negedge i_rstn) begin
        if (!i_rstn) begin
            start_tgl <= 1'b0;
        end else if (i_scl) begin
            start_tgl <= ~start_tgl;
        end
    end

    always_ff @(posedge i_sda or negedge i_rstn) begin
        if (!i_rstn) begin
            stop_tgl <= 1'b0;
        end else if (i_scl) begin
            stop_tgl <= ~stop_tgl;
        end
    end

    assign start_pend = start_tgl ^ start_seen;
    assign stop_pend  = stop_tgl ^ stop_seen;

    // ------------------------------------------------------------
    // Serial clock domain: bit engine
    // ------------------------------------------------------------
    srs_pkg::srs_state_t    state;
    logic [3:0]             bitcnt;
    logic [7:0]             shift;
    logic [7:0]             byte_now;
    logic [7:0]             addr;
    logic [7:0]             tx;
    logic                   ack;
    logic                   oe_q;
    logic [1:0]             sel_sync;
    logic [6:0]             dev_addr;
    logic [7:0]             wr_addr;
    logic [7:0]             wr_data;
    logic                   wr_tgl;
    logic [7:0]             regs [0:`SRS_REG_COUNT-1];

    function automatic logic [7:0] sat_next(input logic [7:0] a);
        sat_next = (a < `SRS_REG_TOP) ? a + 8'h01 : `SRS_REG_TOP;
    endfunction

    assign byte_now = {shift[6:0], i_sda};
    assign dev_addr = {`SRS_DEV_ADDR_HI, sel_sync[1]};

    always_ff @(posedge i_scl or negedge i_rstn) begin
        if (!i_rstn) begin
            sel_sync <= 2'h0;
        end else begin
            sel_sync <= {sel_sync[0], i_slave_address_select_pin};
        end
    end

    always_ff @(posedge i_scl or negedge i_rstn) begin
        if (!i_rstn) begin
            start_seen <= 1'b0;
            stop_seen  <= 1'b0;
        end else begin
            start_seen <= start_tgl;
            stop_seen  <= stop_tgl;
        end
    end

    always_ff @(posedge i_scl or negedge i_rstn) begin
        if (!i_rstn) begin
            state  <= srs_pkg::SRS_IDLE;
            bitcnt <= 4'h0;
            shift  <= 8'h00;
            ack    <= 1'b0;
            addr   <= 8'h00;
            tx     <= 8'h00;
        end else if (start_pend) begin
            state  <= srs_pkg::SRS_ADDR;
            bitcnt <= 4'h1;
            shift  <= {7'h00, i_sda};
            ack    <= 1'b0;
        end else if (stop_pend) begin
            state  <= srs_pkg::SRS_IDLE;
            bitcnt <= 4'h0;
            ack    <= 1'b0;
        end else if (bitcnt != `SRS_ACK_SLOT) begin
            shift  <= byte_now;
            bitcnt <= bitcnt + 4'h1;
            if (bitcnt == `SRS_LAST_BIT) begin
                case (state)
                    srs_pkg::SRS_ADDR: begin
                        if (byte_now[7:1] == dev_addr) begin
                            ack <= 1'b1;
                        end else begin
                            state <= srs_pkg::SRS_IGNORE;
                        end
                    end
                    srs_pkg::SRS_REG: begin
                        if (byte_now <= `SRS_REG_TOP) begin
                            ack  <= 1'b1;
                            addr <= byte_now;
                        end else begin
                            state <= srs_pkg::SRS_IGNORE;
                        end
                    end
                    srs_pkg::SRS_WDATA: begin
                        ack  <= 1'b1;
                        addr <= sat_next(addr);
                    end
                    default: begin
                        ack <= 1'b0;
                    end
                endcase
            end
        end else begin
            bitcnt <= 4'h0;
            ack    <= 1'b0;
            case (state)
                srs_pkg::SRS_ADDR: begin
                    if (shift[0]) begin
                        state <= srs_pkg::SRS_RDATA;
                        tx    <= regs[addr[4:0]];
                    end else begin
                        state <= srs_pkg::SRS_REG;
                    end
                end
                srs_pkg::SRS_REG: begin
                    state <= srs_pkg::SRS_WDATA;
                end
                srs_pkg::SRS_RDATA: begin
                    if (i_sda) begin
                        state <= srs_pkg::SRS_IGNORE;
                    end else begin
                        addr <= sat_next(addr);
                        tx   <= regs[5'(sat_next(addr))];
                    end
                end
                default: begin
                    state <= state;
                end
            endcase
        end
    end

    // Write request handed to the system clock domain
    always_ff @(posedge i_scl or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
            wr_tgl  <= 1'b0;
        end else if (!start_pend && !stop_pend && bitcnt == `SRS_LAST_BIT
                     && state == srs_pkg::SRS_WDATA) begin
            wr_addr <= addr;
            wr_data <= byte_now;
            wr_tgl  <= ~wr_tgl;
        end
    end

    // ------------------------------------------------------------
    // Data line drive, changed while the clock is low
    // ------------------------------------------------------------
    always_ff @(negedge i_scl or negedge i_rstn) begin
        if (!i_rstn) begin
            oe_q <= 1'b0;
        end else if (start_pend || stop_pend) begin
            oe_q <= 1'b0;
        end else if (bitcnt == `SRS_ACK_SLOT) begin
            oe_q <= ack;
        end else if (state == srs_pkg::SRS_RDATA) begin
            oe_q <= ~tx[3'h7 - bitcnt[2:0]];
        end else begin
            oe_q <= 1'b0;
        end
    end

    // Release at once on a start or stop so the master owns the line
    assign o_sda_oe  = oe_q & ~start_pend & ~stop_pend;
    assign o_sda_out = 1'b0;

    // ------------------------------------------------------------
    // System clock domain: register file
    // ------------------------------------------------------------
    logic [2:0]             wsync;
    logic                   wr_evt;

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            wsync <= 3'h0;
        end else begin
            wsync <= {wsync[1:0], wr_tgl};
        end
    end

    assign wr_evt = wsync[2] ^ wsync[1];

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            o_reg_write <= 1'b0;
            o_reg_addr  <= 8'h00;
            o_reg_data  <= 8'h00;
        end else begin
            o_reg_write <= wr_evt;
            if (wr_evt) begin
                o_reg_addr <= wr_addr;
                o_reg_data <= wr_data;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int i = 0; i < `SRS_REG_COUNT; i++) begin
                regs[i] <= `SRS_REG_RESET;
            end
        end else if (wr_evt) begin
            regs[wr_addr[4:0]] <= wr_data;
        end
    end

    genvar g;
    generate
        for (g = 0; g < `SRS_REG_COUNT; g++) begin : g_flat
            assign o_reg_file[g*8 +: 8] = regs[g];
        end
    endgenerate

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_byte_end(srs_pkg::srs_state_t st);
        !start_pend && !stop_pend && bitcnt == `SRS_LAST_BIT && state == st;
    endsequence

    sequence s_ack_slot(srs_pkg::srs_state_t st);
        !start_pend && !stop_pend && bitcnt == `SRS_ACK_SLOT && state == st;
    endsequence

    addr_match_ack_a: assert property (@(posedge i_scl) disable iff (!i_rstn)
        s_byte_end(srs_pkg::SRS_ADDR) ##0 (byte_now[7:1] == dev_addr) |=> ack && o_sda_oe && bitcnt == `SRS_ACK_SLOT)
        else $error("matched address not acknowledged");

    addr_miss_ignore_a: assert property (@(posedge i_scl) disable iff (!i_rstn)
        s_byte_end(srs_pkg::SRS_ADDR) ##0 (byte_now[7:1] != dev_addr)
        |=> !ack && state == srs_pkg::SRS_IGNORE)
        else $error("mismatched address not ignored");

    reg_range_nack_a: assert property (@(posedge i_scl) disable iff (!i_rstn)
        s_byte_end(srs_pkg::SRS_REG) ##0 (byte_now > `SRS_REG_TOP)
        |=> !ack && !o_sda_oe)
        else $error("out of range base address acknowledged");

    base_store_a: assert property (@(posedge i_scl) disable iff (!i_rstn)
        s_byte_end(srs_pkg::SRS_REG) ##0 (byte_now <= `SRS_REG_TOP) |=> addr == $past(byte_now))
        else $error("base address not stored");

    write_incr_a: assert property (@(posedge i_scl) disable iff (!i_rstn)
        s_byte_end(srs_pkg::SRS_WDATA) |=> addr == sat_next($past(addr)) && wr_addr == $past(addr))
        else $error("write address not advanced");

    read_nack_end_a: assert property (@(posedge i_scl) disable iff (!i_rstn)
        s_ack_slot(srs_pkg::SRS_RDATA) ##0 i_sda |=> state == srs_pkg::SRS_IGNORE ##0 !o_sda_oe)
        else $error("read not ended on missing acknowledge");

    read_incr_a: assert property (@(posedge i_scl) disable iff (!i_rstn)
        s_ack_slot(srs_pkg::SRS_RDATA) ##0 !i_sda |=> addr == sat_next($past(addr)) && tx == regs[addr[4:0]])
        else $error("read address not advanced");

    restart_a: assert property (@(posedge i_scl) disable iff (!i_rstn)
        start_pend |=> state == srs_pkg::SRS_ADDR && bitcnt == 4'h1 && !ack)
        else $error("start not restarting address phase");

    reg_write_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
        wr_evt |=> o_reg_write && regs[o_reg_addr[4:0]] == o_reg_data)
        else $error("register write not applied");

endmodule

// ===== sim/srs_master_model.sv
// Behavioural two-wire bus master for the register access slave
`timescale 1ns/1ps
module srs_master_model (
    output logic      o_scl,
    output logic      o_sda,
    input  wire logic i_sda
);
    // ------------------------------
    // Bus conditions, clock idles high
    // ------------------------------
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic start();
        o_sda = 1'b1;
        #20 o_scl = 1'b1;
        #20 o_sda = 1'b0;
        #20 o_scl = 1'b0;
        #20;
    endtask
    task automatic stop();
        o_sda = 1'b0;
        #20 o_scl = 1'b1;
        #20 o_sda = 1'b1;
        #40;
    endtask
    task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            o_sda = tx[i];
            #20 o_scl = 1'b1;
            #40 rx[i] = i_sda;
            o_scl = 1'b0;
            #20;
        end
        o_sda = ack_in;
        #20 o_scl = 1'b1;
        #40 ack = i_sda;
        o_scl = 1'b0;
        #20;
    endtask
endmodule

// ===== sim/serial_register_access_slave_tb_top.sv
// Random and corner-case bench of the two-wire register access slave
`timescale 1ns/1ps
`include "srs_regs.svh"
module serial_register_access_slave_tb_top;
    logic                        i_clock = 1'b0;
    logic                        i_rstn  = 1'b0;
    logic                        sel     = 1'b0;
    logic                        scl;
    logic                        m_sda;
    wire logic                   sda;
    logic                        oe;
    logic                        sout;
    logic [`SRS_REG_COUNT*8-1:0] regs;
    logic                        reg_write;
    logic [7:0]                  reg_addr;
    logic [7:0]                  reg_data;
    int                          wr_pulses = 0;
    logic [7:0]                  exp_reg [0:`SRS_REG_COUNT-1];
    logic [7:0]                  rx;
    logic                        ack;
    int                          error_cnt = 0;
    int                          checks    = 0;

    always #25 i_clock = ~i_clock;
    // Open-drain line with pull-up
    assign sda = m_sda & ~(oe & ~sout);

    srs_slave dut (
        .i_clock                    (i_clock),
        .i_rstn                     (i_rstn),
        .i_scl                      (scl),
        .i_sda                      (sda),
        .o_sda_out                  (sout),
        .o_sda_oe                   (oe),
        .i_slave_address_select_pin (sel),
        .o_reg_write                (reg_write),
        .o_reg_addr                 (reg_addr),
        .o_reg_data                 (reg_data),
        .o_reg_file                 (regs)
    );
    srs_master_model m (.o_scl(scl), .o_sda(m_sda), .i_sda(sda));

    // One count per write pulse, looked at mid-cycle
    always @(negedge i_clock)
        if (reg_write === 1'b1) wr_pulses++;

    // Next expected register index, held at the top
    function automatic logic [7:0] exp_step(input logic [7:0] a);
        return (a < `SRS_REG_TOP) ? a + 8'h01 : a;
    endfunction

    // ------------------------------
    // Checking helpers
    // ------------------------------
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic regs_chk();
        for (int r = 0; r < `SRS_REG_COUNT; r++)
            chk("register", exp_reg[r], regs[8*r+:8]);
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ------------------------------
    // Transfers
    // ------------------------------
    task automatic do_write(input logic [7:0] base, input int n, input logic rs);
        logic [7:0] d;
        logic [7:0] a;
        logic [7:0] r;
        logic       k;
        logic       bad;
        int         p0;
        logic [7:0] la;
        bad = base > `SRS_REG_TOP;
        p0  = wr_pulses;
        la  = base;
        m.start();
        m.xfer({`SRS_DEV_ADDR_HI, sel, 1'b0}, 1'b1, r, k);
        chk("address ack", 8'h00, {7'h00, k});
        m.xfer(base, 1'b1, r, k);
        chk("base ack", {7'h00, bad}, {7'h00, k});
        a = base;
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            m.xfer(d, 1'b1, r, k);
            chk("data ack", {7'h00, bad}, {7'h00, k});
            if (!bad) begin
                exp_reg[a] = d;
                la = a;
                a = exp_step(a);
            end
        end
        if (!rs) begin
            m.stop();
            repeat (20) @(negedge i_clock);
            regs_chk();
            chk("write pulses", bad ? 8'h00 : 8'(n), 8'(wr_pulses - p0));
            if (!bad && n > 0) begin
                chk("write address", la, reg_addr);
                chk("write data", exp_reg[la], reg_data);
            end
        end
    endtask
    task automatic do_read(input logic [7:0] base, input int n, input logic rs);
        logic [7:0] a;
        logic [7:0] r;
        logic       k;
        do_write(base, 0, rs);
        m.start();
        m.xfer({`SRS_DEV_ADDR_HI, sel, 1'b1}, 1'b1, r, k);
        chk("read address ack", 8'h00, {7'h00, k});
        a = base;
        for (int i = 0; i < n; i++) begin
            m.xfer(8'hFF, i == n - 1, r, k);
            chk("read data", exp_reg[a], r);
            a = exp_step(a);
        end
        chk("released", 8'h00, {7'h00, oe});
        m.stop();
    endtask

    initial begin
        #5ms;
        error_cnt++;
        report_and_stop();
    end

    initial begin
        void'($urandom(32'hd840591e));
        for (int r = 0; r < `SRS_REG_COUNT; r++)
            exp_reg[r] = `SRS_REG_RESET;
        repeat (8) @(negedge i_clock);
        i_rstn = 1'b1;
        regs_chk();
        do_write(8'h00, 4, 1'b0);
        do_write(8'h18, 3, 1'b0);
        do_write(8'h1A, 2, 1'b0);
        do_write(8'hFF, 1, 1'b0);
        m.start();
        m.xfer({`SRS_DEV_ADDR_HI, ~sel, 1'b0}, 1'b1, rx, ack);
        chk("foreign ack", 8'h01, {7'h00, ack});
        m.xfer(8'h01, 1'b1, rx, ack);
        chk("ignored ack", 8'h01, {7'h00, ack});
        m.stop();
        regs_chk();
        do_read(8'h00, 4, 1'b1);
        do_read(8'h18, 3, 1'b0);
        for (int t = 0; t < 8; t++) begin
            @(negedge i_clock);
            sel = 1'($urandom);
            do_write(8'($urandom % 26), 1 + $urandom % 4, 1'b0);
            do_read(8'($urandom % 26), 1 + $urandom % 4, 1'($urandom));
        end
        report_and_stop();
    end
endmodule
